/* rtl/sld_lcd_driver.sv */
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - The LCD clock comes from the external reference when the source bit is 0, the bus clock when 1.
// - Setting the pump enable bit turns on the charge pump.
// - The multiplier select bit picks doubler at 0 and tripler at 1.
// - The bias buffer bypass bit gives buffered drive at 0 and unbuffered drive at 1.
// - Supply select 10 sets the power switches for external supply through the LCD supply pin.
// - With the wait keep-on bit at 0 the drive turns off during wait mode.
// - With the deep-stop keep-on bit at 0 the drive turns off during deep stop mode.
// - Duty value 10 gives 1/3 duty with three backplanes and up to 41 frontplanes.
// - The blink-all bit chooses per-segment blinking at 0 and blinking of every segment at 1.
// - Six 8-bit enable banks hold one bit per frontplane and only enabled frontplanes drive.
// - Blink frequency is the base clock over 2^(5 + rate), from 32 to 4096.
// - The shared pin is a fourth backplane or an extra frontplane according to duty.
module sld_lcd_driver
    import sld_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_ext_ref_clk,
    input wire logic i_wait_mode,
    input wire logic i_deep_stop_mode,
    output logic [2:0] o_backplane,
    output logic [39:0] o_frontplane,
    output logic o_shared_plane_pin,
    output logic o_shared_is_backplane,
    output logic o_plane_drive_en,
    output logic o_pump_enable,
    output logic o_pump_tripler,
    output logic o_bias_unbuffered,
    output logic o_high_drive_buffer,
    output logic [1:0] o_supply_switch,
    output logic o_external_supply
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] clock_reg_ff;
    logic [7:0] power_reg_ff;
    logic [7:0] lowpwr_reg_ff;
    logic [7:0] control_reg_ff;
    logic [7:0] blink_reg_ff;
    logic [7:0] fpen_ff [FPEN_BANKS];
    logic [7:0] segment_memory [NUM_FP];
    logic wb_req;
    logic wb_wr;
    logic [7:0] wr_byte;
    logic [7:0] nxt_rd_byte;
    logic [40:0] fp_enable_vec;

    // Single-cycle request detect; ack drops the cycle after it is given
    assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wb_wr = wb_req && i_wb_we && i_wb_sel[0];
    assign wr_byte = i_wb_dat[7:0];

    // Acknowledge every request, mapped or not, one cycle after it arrives
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= wb_req;
        end
    end

    // Configuration registers
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clock_reg_ff <= RST_CLOCK;
            power_reg_ff <= RST_POWER;
            lowpwr_reg_ff <= RST_LOWPWR;
            control_reg_ff <= RST_CONTROL;
            blink_reg_ff <= RST_BLINK;
        end else if (wb_wr) begin
            unique case (i_wb_adr)
                OFS_CLOCK: clock_reg_ff <= wr_byte & 8'h71;
                OFS_POWER: power_reg_ff <= wr_byte;
                OFS_LOWPWR: lowpwr_reg_ff <= wr_byte & 8'h03;
                OFS_CONTROL: control_reg_ff <= wr_byte & 8'h83;
                OFS_BLINK: blink_reg_ff <= wr_byte & 8'h8F;
                default: ;
            endcase
        end
    end

    // Frontplane enable banks; unused bits of the last bank stay zero
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int b = 0; b < FPEN_BANKS; b++) begin
                fpen_ff[b] <= 8'h00;
            end
        end else begin
            for (int b = 0; b < FPEN_BANKS; b++) begin
                if (wb_wr && i_wb_adr == OFS_FPEN0 + 8'(4 * b)) begin
                    fpen_ff[b] <= (b == FPEN_BANKS - 1) ? (wr_byte & 8'h01) : wr_byte;
                end
            end
        end
    end

    // Segment memory: low nibble segment on per backplane, high nibble blink select
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int n = 0; n < NUM_FP; n++) begin
                segment_memory[n] <= 8'h00;
            end
        end else begin
            for (int n = 0; n < NUM_FP; n++) begin
                if (wb_wr && i_wb_adr == OFS_SEGMEM + 8'(4 * n)) begin
                    segment_memory[n] <= wr_byte;
                end
            end
        end
    end

    // Flattened enable vector, one bit per frontplane
    always_comb begin
        fp_enable_vec = {fpen_ff[5][0], fpen_ff[4], fpen_ff[3], fpen_ff[2],
                         fpen_ff[1], fpen_ff[0]};
    end

    // ****************************************************************
    // Clock source and base clock
    // ****************************************************************
    logic ref_s1_ff;
    logic ref_s2_ff;
    logic ref_s3_ff;
    logic ref_level_ff;
    logic ref_rise;
    logic [9:0] bus_pre_ff;
    logic bus_tick;
    logic lcd_tick;
    logic [10:0] base_cnt_ff;
    logic [10:0] base_mask;
    logic base_tick;
    logic [2:0] prescale;

    // Reference pin passes three flip-flops; a change counts once two agree
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ref_s1_ff <= 1'b0;
            ref_s2_ff <= 1'b0;
            ref_s3_ff <= 1'b0;
            ref_level_ff <= 1'b0;
        end else begin
            ref_s1_ff <= i_ext_ref_clk;
            ref_s2_ff <= ref_s1_ff;
            ref_s3_ff <= ref_s2_ff;
            if (ref_s2_ff == ref_s3_ff) begin
                ref_level_ff <= ref_s3_ff;
            end
        end
    end
    assign ref_rise = (ref_s2_ff == ref_s3_ff) && ref_s3_ff && !ref_level_ff;

    // Bus clock prescaler toward the reference rate
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_pre_ff <= 10'h000;
        end else if (bus_tick) begin
            bus_pre_ff <= 10'h000;
        end else begin
            bus_pre_ff <= bus_pre_ff + 10'h001;
        end
    end
    assign bus_tick = (bus_pre_ff == BUS_PREDIV_CYC - 10'h001);

    // Source select picks reference edges or bus prescale ticks
    assign lcd_tick = clock_reg_ff[CLK_SRC_BIT] ? bus_tick : ref_rise;

    // Base clock is the LCD clock over 2^(4 + prescale)
    assign prescale = clock_reg_ff[CLK_PRE_LSB +: 3];
    assign base_mask = 11'((12'h001 << (BASE_SHIFT + 4'(prescale))) - 12'h001);
    assign base_tick = lcd_tick && ((base_cnt_ff & base_mask) == base_mask);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            base_cnt_ff <= 11'h000;
        end else if (lcd_tick) begin
            base_cnt_ff <= base_cnt_ff + 11'h001;
        end
    end

    // ****************************************************************
    // Frame phase sequencing and blinking
    // ****************************************************************
    logic [1:0] duty;
    logic [1:0] phase_ff;
    logic [11:0] blink_cnt_ff;
    logic [11:0] blink_half;
    logic blank_ff;
    logic blink_wrap;

    assign duty = control_reg_ff[1:0];

    // One phase per base tick; duty + 1 phases make one frame
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_ff <= 2'h0;
        end else if (phase_ff > duty) begin
            phase_ff <= 2'h0;
        end else if (base_tick) begin
            phase_ff <= (phase_ff == duty) ? 2'h0 : phase_ff + 2'h1;
        end
    end

    // Half-period of the blink divider 2^(5 + rate) is 2^(4 + rate) base ticks
    assign blink_half = 12'((13'h0001 << (BLINK_SHIFT - 4'h1 + 4'(blink_reg_ff[2:0])))
                            - 13'h0001);
    assign blink_wrap = base_tick && ((blink_cnt_ff & blink_half) == blink_half);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blink_cnt_ff <= 12'h000;
        end else if (!blink_reg_ff[BLK_EN_BIT]) begin
            blink_cnt_ff <= 12'h000;
        end else if (base_tick) begin
            blink_cnt_ff <= blink_cnt_ff + 12'h001;
        end
    end

    // Blank state flips every half-period while blinking is on
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blank_ff <= 1'b0;
        end else if (!blink_reg_ff[BLK_EN_BIT]) begin
            blank_ff <= 1'b0;
        end else if (blink_wrap) begin
            blank_ff <= !blank_ff;
        end
    end

    // ****************************************************************
    // Plane waveforms
    // ****************************************************************
    logic drive_on;
    logic [3:0] nxt_bp;
    logic [40:0] nxt_fp;
    logic shared_is_bp;

    // Low power modes gate the drive unless their keep-on bit is set
    assign drive_on = control_reg_ff[CTL_ENABLE_BIT]
                      && !(i_wait_mode && !lowpwr_reg_ff[LP_WAIT_BIT])
                      && !(i_deep_stop_mode && !lowpwr_reg_ff[LP_STOP_BIT]);

    assign shared_is_bp = (duty == DUTY_QUARTER);

    // Active backplane is one-hot on the current phase
    always_comb begin
        nxt_bp = drive_on ? (4'h1 << phase_ff) : 4'h0;
    end

    // Frontplane drives its segment bit for the current phase
    always_comb begin
        nxt_fp = '0;
        for (int n = 0; n < NUM_FP; n++) begin
            if (drive_on && fp_enable_vec[n]) begin
                if (blank_ff && (blink_reg_ff[BLK_ALL_BIT]
                                 || segment_memory[n][4 + phase_ff])) begin
                    nxt_fp[n] = 1'b0;
                end else begin
                    nxt_fp[n] = segment_memory[n][phase_ff];
                end
            end
        end
    end

    // Registered plane outputs
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_backplane <= 3'h0;
            o_frontplane <= 40'h00_0000_0000;
            o_shared_plane_pin <= 1'b0;
            o_shared_is_backplane <= 1'b0;
            o_plane_drive_en <= 1'b0;
        end else begin
            o_backplane <= nxt_bp[2:0];
            o_frontplane <= nxt_fp[39:0];
            o_shared_plane_pin <= shared_is_bp ? nxt_bp[3] : nxt_fp[40];
            o_shared_is_backplane <= shared_is_bp;
            o_plane_drive_en <= drive_on;
        end
    end

    // ****************************************************************
    // Charge pump and supply switches
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pump_enable <= 1'b0;
            o_pump_tripler <= 1'b0;
            o_bias_unbuffered <= 1'b0;
            o_high_drive_buffer <= 1'b0;
            o_supply_switch <= 2'h0;
            o_external_supply <= 1'b0;
        end else begin
            o_pump_enable <= power_reg_ff[PWR_PUMP_EN_BIT];
            o_pump_tripler <= power_reg_ff[PWR_TRIPLER_BIT];
            o_bias_unbuffered <= power_reg_ff[PWR_BYPASS_BIT];
            o_high_drive_buffer <= power_reg_ff[PWR_HDRV_BIT];
            o_supply_switch <= power_reg_ff[1:0];
            o_external_supply <= (power_reg_ff[1:0] == SUPPLY_EXTERNAL);
        end
    end

    // ****************************************************************
    // Read back
    // ****************************************************************
    always_comb begin
        nxt_rd_byte = 8'h00;
        unique case (i_wb_adr)
            OFS_CLOCK: nxt_rd_byte = clock_reg_ff;
            OFS_POWER: nxt_rd_byte = power_reg_ff;
            OFS_LOWPWR: nxt_rd_byte = lowpwr_reg_ff;
            OFS_CONTROL: nxt_rd_byte = control_reg_ff;
            OFS_BLINK: nxt_rd_byte = blink_reg_ff;
            OFS_STATUS: nxt_rd_byte = {4'h0, drive_on, blank_ff, phase_ff};
            default: begin
                for (int b = 0; b < FPEN_BANKS; b++) begin
                    if (i_wb_adr == OFS_FPEN0 + 8'(4 * b)) begin
                        nxt_rd_byte = fpen_ff[b];
                    end
                end
                for (int n = 0; n < NUM_FP; n++) begin
                    if (i_wb_adr == OFS_SEGMEM + 8'(4 * n)) begin
                        nxt_rd_byte = segment_memory[n];
                    end
                end
            end
        endcase
    end

    // Read data registered alongside ack
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (wb_req && !i_wb_we) begin
            o_wb_dat <= {24'h00_0000, nxt_rd_byte};
        end
    end

endmodule

/* rtl/sld_pkg.sv */
package sld_pkg;

    // ****************************************************************
    // Clock rates and derived counts
    // ****************************************************************
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam int REF_CLK_HZ = 32_768;
    // Bus clock prescale so the bus source runs near the reference rate
    localparam int BUS_PREDIV_CYC_I = SYS_CLK_HZ / REF_CLK_HZ;
    localparam logic [9:0] BUS_PREDIV_CYC = BUS_PREDIV_CYC_I[9:0];
    // LCD clock to base clock divider is 2^(BASE_SHIFT + prescale)
    localparam logic [3:0] BASE_SHIFT = 4'h4;
    // Blink divider is 2^(BLINK_SHIFT + rate); half-period is one less
    localparam logic [3:0] BLINK_SHIFT = 4'h5;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CLOCK = 8'h00;
    localparam logic [7:0] OFS_POWER = 8'h04;
    localparam logic [7:0] OFS_LOWPWR = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0C;
    localparam logic [7:0] OFS_BLINK = 8'h10;
    localparam logic [7:0] OFS_FPEN0 = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    localparam logic [7:0] OFS_SEGMEM = 8'h40;
    localparam int FPEN_BANKS = 6;
    localparam int NUM_FP = 41;
    localparam int NUM_BP = 4;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CLK_SRC_BIT = 0;
    localparam int CLK_PRE_LSB = 4;
    localparam int PWR_PUMP_EN_BIT = 7;
    localparam int PWR_TRIPLER_BIT = 6;
    localparam int PWR_HDRV_BIT = 5;
    localparam int PWR_BYPASS_BIT = 2;
    localparam int LP_WAIT_BIT = 1;
    localparam int LP_STOP_BIT = 0;
    localparam int CTL_ENABLE_BIT = 7;
    localparam int BLK_ALL_BIT = 7;
    localparam int BLK_EN_BIT = 3;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [7:0] RST_CLOCK = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_LOWPWR = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_BLINK = 8'h00;
    localparam logic [1:0] SUPPLY_EXTERNAL = 2'h2;
    localparam logic [1:0] DUTY_THIRD = 2'h2;
    localparam logic [1:0] DUTY_QUARTER = 2'h3;

endpackage

/* tb/sld_lcd_driver_checker.sv */
`timescale 1ns/1ps
module sld_lcd_driver_checker
    import sld_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire logic i_wait_mode,
    input wire logic i_deep_stop_mode,
    input wire logic [2:0] o_backplane,
    input wire logic o_shared_is_backplane,
    input wire logic o_plane_drive_en,
    input wire logic o_pump_enable,
    input wire logic o_pump_tripler,
    input wire logic o_bias_unbuffered,
    input wire logic [1:0] o_supply_switch,
    input wire logic o_external_supply
);
    logic acc;
    logic [1:0] keep_ff;
    logic [1:0] duty_ff;

    // Write taken at the edge where the slave latches it, before ack rises
    assign acc = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] && !o_wb_ack;

    // Shadow of keep-on bits and duty
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            keep_ff <= 2'h0;
            duty_ff <= 2'h0;
        end else begin
            if (acc && i_wb_adr == OFS_LOWPWR) begin
                keep_ff <= i_wb_dat[1:0];
            end
            if (acc && i_wb_adr == OFS_CONTROL) begin
                duty_ff <= i_wb_dat[1:0];
            end
        end
    end

    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    property p_ack;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack timing wrong");
    property p_pump;
        acc && i_wb_adr == OFS_POWER |-> ##2 o_pump_enable == $past(i_wb_dat[7], 2);
    endproperty
    a_pump: assert property (p_pump)
        else $error("pump enable wrong");
    property p_trip;
        acc && i_wb_adr == OFS_POWER |-> ##2 o_pump_tripler == $past(i_wb_dat[6], 2);
    endproperty
    a_trip: assert property (p_trip)
        else $error("multiplier wrong");
    property p_bypass;
        acc && i_wb_adr == OFS_POWER |-> ##2 o_bias_unbuffered == $past(i_wb_dat[2], 2);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bias bypass wrong");
    property p_ext;
        acc && i_wb_adr == OFS_POWER |-> ##2
            {o_supply_switch, o_external_supply} ==
            {$past(i_wb_dat[1:0], 2), $past(i_wb_dat[1:0], 2) == SUPPLY_EXTERNAL};
    endproperty
    a_ext: assert property (p_ext)
        else $error("external supply wrong");
    property p_wait;
        i_wait_mode && !keep_ff[LP_WAIT_BIT] |=> !o_plane_drive_en;
    endproperty
    a_wait: assert property (p_wait)
        else $error("drive on in wait");
    property p_stop;
        i_deep_stop_mode && !keep_ff[LP_STOP_BIT] |=> !o_plane_drive_en;
    endproperty
    a_stop: assert property (p_stop)
        else $error("drive on in deep stop");
    property p_shared;
        1'b1 |=> o_shared_is_backplane == $past(duty_ff == DUTY_QUARTER);
    endproperty
    a_shared: assert property (p_shared)
        else $error("shared pin role wrong");
    property p_bp;
        $onehot0(o_backplane);
    endproperty
    a_bp: assert property (p_bp)
        else $error("backplanes overlap");
endmodule

/* tb/sld_glass_model.sv */
`timescale 1ns/1ps
module sld_glass_model (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_clear,
    input wire logic [2:0] i_backplane,
    input wire logic i_shared_plane_pin,
    input wire logic i_shared_is_backplane,
    input wire logic i_plane_drive_en,
    output logic [3:0] o_seen
);
    // Records which backplane electrodes the glass saw driven
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_seen <= 4'h0;
        end else if (i_clear) begin
            o_seen <= 4'h0;
        end else if (i_plane_drive_en) begin
            o_seen <= o_seen | {i_shared_is_backplane & i_shared_plane_pin, i_backplane};
        end
    end
endmodule

/* tb/sld_lcd_driver_test.sv */
`timescale 1ns/1ps
module sld_lcd_driver_test
    import sld_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ref_clk = 1'b0;
    logic wait_m = 1'b0, stop_m = 1'b0, clear = 1'b0, ref_run = 1'b0, ack;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00, v;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [2:0] bp, ref_div = 3'h0;
    logic [39:0] fp;
    logic [3:0] seen;
    logic spin, sbp, den, pump, trip, unbuf, hdrv, ext;
    logic [1:0] sw;
    logic [7:0] exp_q[$];
    int error_cnt = 0, cmp_count = 0, cyc_cnt = 0, n, k;

    sld_lcd_driver i_sld_lcd_driver (.i_sys_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_ext_ref_clk(ref_clk), .i_wait_mode(wait_m),
        .i_deep_stop_mode(stop_m), .o_backplane(bp), .o_frontplane(fp),
        .o_shared_plane_pin(spin), .o_shared_is_backplane(sbp), .o_plane_drive_en(den),
        .o_pump_enable(pump), .o_pump_tripler(trip), .o_bias_unbuffered(unbuf),
        .o_high_drive_buffer(hdrv), .o_supply_switch(sw), .o_external_supply(ext));
    sld_glass_model i_sld_glass_model (.i_sys_clk(clk), .i_nrst(nrst), .i_clear(clear),
        .i_backplane(bp), .i_shared_plane_pin(spin), .i_shared_is_backplane(sbp),
        .i_plane_drive_en(den), .o_seen(seen));

    // ****************************************************************
    // Clocks, reference clock and watchdog
    // ****************************************************************
    initial begin
        forever #20 clk = ~clk;
    end
    // Reference clock of ten system cycles while running
    always @(posedge clk) begin
        if (ref_run) begin
            ref_div <= (ref_div == 3'h4) ? 3'h0 : ref_div + 3'h1;
            ref_clk <= ref_clk ^ (ref_div == 3'h4);
        end
    end
    // Timeout and read-data monitor
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 90000) begin
            error_cnt++;
            finish_test();
        end
        if (ack && cyc && !we) begin
            cmp_rd(rdat);
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [31:0] got);
        logic [7:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
        chk(48'(got), 48'(e));
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= 32'(d);
        sel <= {3'h0, s};
        @(posedge clk);
        while (!ack) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 8'h00, 1'b1);
    endtask
    // Cycles between two changes of frontplane 5
    task automatic gap(output int c);
        logic l;
        l = fp[5];
        while (fp[5] === l) @(posedge clk);
        l = fp[5];
        c = 0;
        while (fp[5] === l) begin
            @(posedge clk);
            c++;
        end
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(58));
        repeat (12) @(posedge clk);
        chk(48'({den, pump, trip, unbuf, hdrv, sw, ext, sbp}), 48'h0);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 8'h00);
        rd(OFS_STATUS, 8'h00);
        wr(OFS_CLOCK, 8'hFF);
        rd(OFS_CLOCK, 8'h71);
        wr(OFS_LOWPWR, 8'hFF);
        rd(OFS_LOWPWR, 8'h03);
        wr(OFS_BLINK, 8'hFF);
        wb(1'b1, OFS_BLINK, 8'h00, 1'b0);
        rd(OFS_BLINK, 8'h8F);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        wr(OFS_CLOCK, 8'h00);
        wr(OFS_BLINK, 8'h00);
        wr(OFS_CONTROL, 8'h80);
        rd(OFS_STATUS, 8'h08);
        ref_run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            v[1:0] = 2'(i);
            wr(OFS_POWER, v);
            rd(OFS_POWER, v);
            chk(48'({pump, trip, hdrv, unbuf, sw, ext}), 48'({v[7:5], v[2:0], v[1:0] == 2'h2}));
        end
        for (int i = 0; i < 16; i++) begin
            {wait_m, stop_m} <= 2'(i >> 2);
            wr(OFS_LOWPWR, 8'(i & 3));
            repeat (3) @(posedge clk);
            chk(48'(den), 48'(!(i[3] && !i[1]) && !(i[2] && !i[0])));
        end
        {wait_m, stop_m} <= 2'h0;
        wr(OFS_SEGMEM + 8'h14, 8'h01);
        wr(OFS_SEGMEM + 8'hA0, 8'h01);
        wr(OFS_FPEN0, 8'h20);
        wr(OFS_FPEN0 + 8'h14, 8'h01);
        repeat (3) @(posedge clk);
        chk(48'({spin, fp}), 48'({1'b1, 40'h00_0000_0020}));
        wr(OFS_FPEN0, 8'h00);
        repeat (3) @(posedge clk);
        chk(48'(fp), 48'h0);
        wr(OFS_FPEN0, 8'h20);
        for (int r = 0; r < 2; r++) begin
            wr(OFS_BLINK, 8'(8'h88 | r));
            gap(n);
            gap(n);
            chk(48'(n), 48'((10 << (BASE_SHIFT + BLINK_SHIFT - 1)) << r));
        end
        wr(OFS_BLINK, 8'h08);
        k = 0;
        repeat (3000) begin
            @(posedge clk);
            if (fp[5] !== 1'b1) k++;
        end
        chk(48'(k), 48'h0);
        wr(OFS_SEGMEM + 8'h14, 8'h11);
        gap(n);
        gap(n);
        chk(48'(n), 48'(10 << (BASE_SHIFT + BLINK_SHIFT - 1)));
        wr(OFS_BLINK, 8'h00);
        for (int d = 0; d < 4; d++) begin
            wr(OFS_CONTROL, 8'(8'h80 | d));
            clear <= 1'b1;
            @(posedge clk);
            clear <= 1'b0;
            repeat (1000) @(posedge clk);
            chk(48'({sbp, seen}), 48'({d == 3, 4'((2 << d) - 1)}));
        end
        wr(OFS_CONTROL, 8'h81);
        ref_run <= 1'b0;
        // Let a last reference edge still in the synchroniser settle
        repeat (8) @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        repeat (2000) @(posedge clk);
        chk(48'($countones(seen)), 48'h1);
        wr(OFS_CLOCK, 8'h01);
        repeat (13500) @(posedge clk);
        chk(48'(seen), 48'h3);
        finish_test();
    end
endmodule

bind sld_lcd_driver sld_lcd_driver_checker i_sld_lcd_driver_checker (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
    .i_wait_mode(i_wait_mode), .i_deep_stop_mode(i_deep_stop_mode), .o_backplane(o_backplane),
    .o_shared_is_backplane(o_shared_is_backplane), .o_plane_drive_en(o_plane_drive_en),
    .o_pump_enable(o_pump_enable), .o_pump_tripler(o_pump_tripler),
    .o_bias_unbuffered(o_bias_unbuffered), .o_supply_switch(o_supply_switch),
    .o_external_supply(o_external_supply));
